// File: verif/timer_output_compare_pwm_tb.sv
// Self-checking bench for the two-channel compare timer.
// Assumes a zero-wait APB slave on pclk and a count pin synchronous to pclk.
`timescale 1ns/1ps
`include "toc_defines.svh"
module timer_output_compare_pwm_tb
  import toc_pkg::*;
;
  logic        pclk;                 // 250 MHz bus clock
  logic        presetn;              // Active-low reset
  logic        psel;                 // APB select
  logic        penable;              // APB access phase
  logic        pwrite;               // APB direction
  logic [7:0]  paddr;                // APB byte address
  logic [31:0] pwdata;               // APB write data
  logic [31:0] prdata;               // APB read data
  logic        pready;               // APB ready
  logic        pslverr;              // APB error
  logic        ext_count_clock_pin;  // External count input
  logic [1:0]  pa, pb, pc, pd;       // Waveform pins, bit i is channel i
  int          err_total;            // Mismatch count
  int          checks;               // Comparison count
  int          cyc;                  // Cycles since time zero
  logic [15:0] lfsr_q;               // Random source state
  logic [31:0] rd;                   // Last read data
  logic        er;                   // Last error response
  int          a, b, c, d, m, n, hi, lo, k;

  timer_output_compare_pwm timer_output_compare_pwm_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_count_clock_pin(ext_count_clock_pin), .wave_pin_a(pa), .wave_pin_b(pb),
    .wave_pin_c(pc), .wave_pin_d(pd));

  // Free-running clock, 4 ns period
  always #2 pclk = ~pclk;

  // Hang guard: the whole run needs well under this many cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end

  // Shift register for repeatable random values
  function automatic logic [15:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q;
  endfunction : rnd

  // Byte address of word idx in channel ch's window
  function automatic logic [7:0] ra(input int ch, input int idx);
    return 8'((ch + 1) * 64 + idx * 4);
  endfunction : ra

  // Status readback: channel 0 always shows the fixed bit 5 as one
  function automatic logic [31:0] st_exp(input int ch, input logic [4:0] f);
    return {26'h0, ch == 0, f};
  endfunction : st_exp

  // Counter advance for four pulses; both edges count twice, none when disabled
  function automatic logic [31:0] ext_exp(input int e);
    return (e == 3) ? 32'h0 : (e == 2) ? 32'h8 : 32'h4;
  endfunction : ext_exp

  task automatic results();
    $display("checks=%0d errors=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer; request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    int w;
    w = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && w < 50) begin
      @(posedge pclk);
      w++;
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [7:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0);
    check(rd, exp);
  endtask : rdchk

  // Times one high and one low stretch of channel 0's pin B
  task automatic measure();
    k = 0;
    hi = 0;
    lo = 0;
    while (pb[0] !== 1'b0 && k < 500) begin
      @(posedge pclk);
      k++;
    end
    while (pb[0] !== 1'b1 && k < 500) begin
      @(posedge pclk);
      k++;
    end
    while (pb[0] === 1'b1 && hi < 500) begin
      @(posedge pclk);
      hi++;
    end
    while (pb[0] === 1'b0 && lo < 500) begin
      @(posedge pclk);
      lo++;
    end
  endtask : measure

  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00;
    pwdata = 32'h0; ext_count_clock_pin = 0; err_total = 0; checks = 0; cyc = 0;
    lfsr_q = 16'hA849;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, fixed status bit, refused address
    for (int i = 0; i < 4; i++) rdchk(ra(0, 5 + i), 32'hFFFF);
    rdchk(ra(0, 3), st_exp(0, 5'h00));
    rdchk(ra(1, 3), st_exp(1, 5'h00));
    apb(1'b0, 8'h18, 32'h0);
    check({rd[30:0], er}, 32'h1);
    // Compare run with distinct random points b<d<c<a, stopping at A
    b = 2 + rnd() % 8;
    d = b + 2 + rnd() % 8;
    c = d + 2 + rnd() % 8;
    a = c + 2 + rnd() % 8;
    m = rnd() % 256;
    apb(1'b1, `OFS_DUTY, 32'(m));
    apb(1'b1, `OFS_POL, 32'h77);
    apb(1'b1, ra(0, 1), 32'h22);
    apb(1'b1, ra(0, 2), 32'h1A);
    apb(1'b1, ra(0, 5), 32'(a));
    apb(1'b1, ra(0, 6), 32'(b));
    apb(1'b1, ra(0, 7), 32'(c));
    apb(1'b1, ra(0, 8), 32'(d));
    apb(1'b1, `OFS_START, 32'h1);
    k = 0;
    do begin
      apb(1'b0, `OFS_START, 32'h0);
      k++;
    end while (rd[0] !== 1'b0 && k < 100);
    check(rd & 32'h1, 32'h0);
    check({pa, pb, pc, pd}, 32'h0000_0044);
    rdchk(`OFS_DUTY, 32'(m));
    // Flag clearing needs a read of one, then a zero written
    apb(1'b1, ra(0, 3), 32'h0);
    rdchk(ra(0, 3), st_exp(0, 5'h0F));
    apb(1'b1, ra(0, 3), 32'h0E);
    rdchk(ra(0, 3), st_exp(0, 5'h0E));
    apb(1'b1, ra(0, 3), 32'h0);
    rdchk(ra(0, 3), st_exp(0, 5'h00));
    // Channel 1: C buffers A, so pin C stays idle and A reloads
    apb(1'b1, `OFS_MODE, 32'h40);
    apb(1'b1, ra(1, 1), 32'h02);
    apb(1'b1, ra(1, 2), 32'h0A);
    apb(1'b1, ra(1, 0), 32'h20);
    apb(1'b1, ra(1, 5), 32'h32);
    apb(1'b1, ra(1, 7), 32'h50);
    apb(1'b1, `OFS_START, 32'h0A);
    repeat (400) @(posedge pclk);
    rdchk(ra(1, 5), 32'h50);
    check({pa[1], pc[1]}, 32'h2);
    rdchk(ra(1, 3), st_exp(1, 5'h05));
    apb(1'b1, `OFS_START, 32'h0);
    apb(1'b1, `OFS_MODE, 32'h0);
    // PWM on pin B of channel 0, active high
    m = 20 + rnd() % 32;
    n = 1 + rnd() % (m - 2);
    apb(1'b1, ra(0, 1), 32'h0);
    apb(1'b1, ra(0, 2), 32'h88);
    apb(1'b1, ra(0, 4), 32'h0);
    apb(1'b1, ra(0, 5), 32'(m));
    apb(1'b1, ra(0, 6), 32'(n));
    apb(1'b1, `OFS_PWMSEL, 32'h1);
    apb(1'b1, `OFS_POL, 32'h1);
    apb(1'b1, `OFS_START, 32'h5);
    measure();
    measure();
    check(32'(hi), 32'(m - n));
    check(32'(lo), 32'(n + 1));
    apb(1'b1, `OFS_START, 32'h0);
    apb(1'b1, `OFS_PWMSEL, 32'h0);
    // External count pin with each edge choice
    apb(1'b1, `OFS_FUNC, 32'h80);
    // Last pass: both edges selected, but the external input is disabled
    for (int e = 0; e < 4; e++) begin
      if (e == 3) apb(1'b1, `OFS_FUNC, 32'h0);
      apb(1'b1, ra(0, 0), 32'((e << 3) | 5));
      apb(1'b1, ra(0, 4), 32'h0);
      apb(1'b1, `OFS_START, 32'h5);
      repeat (4) begin
        @(posedge pclk);
        ext_count_clock_pin <= 1'b1;
        repeat (3) @(posedge pclk);
        ext_count_clock_pin <= 1'b0;
        repeat (3) @(posedge pclk);
      end
      repeat (4) @(posedge pclk);
      apb(1'b1, `OFS_START, 32'h4);
      rdchk(ra(0, 4), ext_exp(e));
    end
    // Synchronous clear: channel 1 wraps with channel 0's A match at 10
    apb(1'b1, `OFS_MODE, 32'h1);
    apb(1'b1, ra(0, 0), 32'h20);
    apb(1'b1, ra(1, 0), 32'h40);
    apb(1'b1, ra(0, 5), 32'hA);
    apb(1'b1, ra(0, 4), 32'h0);
    apb(1'b1, ra(1, 4), 32'h0);
    apb(1'b1, `OFS_START, 32'hF);
    repeat (40) @(posedge pclk);
    apb(1'b1, `OFS_START, 32'hC);
    // 43 ticks from the start edge to the stop edge, period of 11 counts
    rdchk(ra(0, 4), 32'(43 % 11));
    rdchk(ra(1, 4), 32'(43 % 11));
    results();
  end
endmodule : timer_output_compare_pwm_tb

// File: verilog/timer_output_compare_pwm.sv
// Two-channel 16-bit timer: output compare with PWM, behind an APB slave.
// Assumes APB master on pclk; external count pin synchronous to pclk.
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "toc_defines.svh"
module timer_output_compare_pwm
  import toc_pkg::*;
#(
  parameter int CW = 16                  // Counter width
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          ext_count_clock_pin,
  output logic      [1:0]    wave_pin_a,
  output logic      [1:0]    wave_pin_b,
  output logic      [1:0]    wave_pin_c,
  output logic      [1:0]    wave_pin_d
);
  // Registered state; armed_q, psc_q and ext_q are not software-visible
  logic [1:0]    count_start_bit;        // Per channel run bit
  logic [1:0]    count_stop_select;      // 0: stop at A match
  logic [7:0]    timer_mode_reg;         // Sync and buffer enables
  logic [7:0]    pwm_sel_q;              // Bits 0..2 ch0 B..D, 4..6 ch1
  logic [7:0]    function_ctrl_reg;      // External clock enable
  logic [7:0]    duty_dt_reg;            // Held only, no effect here
  logic [7:0]    pwm_polarity_reg;       // Active level per PWM pin
  logic [7:0]    ctrl_q   [2];           // Source, edge, clear selects
  logic [7:0]    io_ctrl_ab_reg [2];     // A in 1:0, B in 5:4
  logic [7:0]    io_ctrl_cd_reg [2];     // C in 3:0, D in 7:4
  logic [CW-1:0] cnt_q    [2];           // Counters
  logic [CW-1:0] gr_q     [2][4];        // compare_reg_a..d
  logic [4:0]    flag_q   [2];           // Match A..D, overflow
  logic [4:0]    armed_q  [2];           // Flags seen as one by a read
  logic [3:0]    pin_q    [2];           // Pin levels A..D
  logic [4:0]    psc_q;                  // Prescaler for internal rates
  logic          ext_q;                  // Previous external pin level
  logic [31:0]   prdata_q;               // Registered read data
  // Bus decode
  logic          setup, wr_en, rd_en, mapped;
  logic [1:0]    win;
  logic [3:0]    idx;
  // Per-channel combinational events
  logic [1:0]    tick, own_clr, clr, ovf;
  logic [3:0]    mt       [2];           // Compare matches A..D
  logic          pwm_any  [2];

  assign setup  = psel & ~penable;
  assign wr_en  = psel & penable & pwrite;
  // Reads act at the setup edge, so flags arm with exactly the value returned
  assign rd_en  = setup & ~pwrite;
  assign win    = paddr[7:6];
  assign idx    = paddr[5:2];
  // Slots 0..5 global, 0..9 per channel window; the rest is an error
  assign mapped = (win == 2'h0) ? (paddr[5:2] <= 4'h5) :
                  (win != 2'h3) ? (idx <= `IDX_PIN) : 1'b0;
  assign pready  = 1'b1;                 // Zero wait states
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = prdata_q;
  // Action of a compare match on a pin level
  function automatic logic act(input logic [1:0] m, input logic cur);
    unique case (out_act_t'(m))
      ACT_NONE:   act = cur;
      ACT_LOW:    act = 1'b0;
      ACT_HIGH:   act = 1'b1;
      ACT_TOGGLE: act = ~cur;
    endcase
  endfunction : act
  // Count source pulse from the source select and edge select
  function automatic logic src_tick(input logic [7:0] c, input logic ext_en,
                                    input logic [4:0] p, input logic rise,
                                    input logic fall);
    logic [1:0] e;
    e = c[`CTRL_EDGE +: 2];
    unique case (c[2:0])
      3'h0:     src_tick = 1'b1;
      3'h1:     src_tick = p[0];
      3'h2:     src_tick = &p[1:0];
      3'h3:     src_tick = &p[2:0];
      3'h4:     src_tick = &p[4:0];
      `SRC_EXT: src_tick = ext_en & ((e == 2'h0) ? rise :
                                     (e == 2'h1) ? fall : rise | fall);
      default:  src_tick = 1'b1;
    endcase
  endfunction : src_tick
  // Ticks, matches, clears and overflow for both channels
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pwm_any[i] = |pwm_sel_q[4*i +: 3];
      tick[i] = count_start_bit[i] &
                src_tick(ctrl_q[i], function_ctrl_reg[`FUNC_EXTEN], psc_q,
                         ext_count_clock_pin & ~ext_q, ~ext_count_clock_pin & ext_q);
      for (int j = 0; j < 4; j++) begin
        mt[i][j] = tick[i] & (cnt_q[i] == gr_q[i][j]);
      end
      // PWM always wraps at A, giving an m+1 period
      own_clr[i] = mt[i][0] & (pwm_any[i] | ctrl_q[i][`CTRL_CLRA]);
    end
    // Cross-channel clear counts only in synchronous operation
    for (int i = 0; i < 2; i++) begin
      clr[i] = own_clr[i] | (timer_mode_reg[`MODE_SYNC] &
               ctrl_q[i][`CTRL_SCLR] & own_clr[1-i]);
      ovf[i] = tick[i] & ~clr[i] & (&cnt_q[i]);
    end
  end
  // Free-running prescaler and external pin history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psc_q <= 5'h00;
      ext_q <= 1'b0;
    end else begin
      psc_q <= psc_q + 5'h01;
      ext_q <= ext_count_clock_pin;
    end
  end

  // Global control registers and run bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_start_bit   <= 2'h0;
      count_stop_select <= 2'h0;
      timer_mode_reg    <= `RST_BYTE;
      pwm_sel_q         <= `RST_BYTE;
      function_ctrl_reg <= `RST_BYTE;
      duty_dt_reg       <= `RST_BYTE;
      pwm_polarity_reg  <= `RST_BYTE;
    end else begin
      for (int i = 0; i < 2; i++) begin
        // Automatic stop at an A match when stop select is 0
        if (mt[i][0] && !count_stop_select[i]) begin
          count_start_bit[i] <= 1'b0;
        end
      end
      if (wr_en && win == 2'h0) begin
        unique case (paddr)
          `OFS_START: begin
            count_start_bit   <= pwdata[1:0];
            count_stop_select <= pwdata[3:2];
          end
          `OFS_MODE:   timer_mode_reg    <= pwdata[7:0];
          `OFS_PWMSEL: pwm_sel_q         <= pwdata[7:0];
          `OFS_FUNC:   function_ctrl_reg <= pwdata[7:0];
          `OFS_DUTY:   duty_dt_reg       <= pwdata[7:0];
          `OFS_POL:    pwm_polarity_reg  <= pwdata[7:0];
          default: ;
        endcase
      end
    end
  end

  // Channel registers, counters, buffer transfer and status flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 2; i++) begin
        ctrl_q[i]         <= `RST_BYTE;
        io_ctrl_ab_reg[i] <= `RST_BYTE;
        io_ctrl_cd_reg[i] <= `RST_BYTE;
        cnt_q[i]          <= '0;
        flag_q[i]         <= 5'h00;
        armed_q[i]        <= 5'h00;
        for (int j = 0; j < 4; j++) gr_q[i][j] <= `RST_GR;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        logic sel_ch;
        logic [4:0] wclr;
        sel_ch = (win == 2'(i + 1));
        wclr   = 5'h00;
        if (tick[i]) cnt_q[i] <= clr[i] ? '0 : cnt_q[i] + CW'(1);
        // Buffered C and D with select 1 feed A and B at the A and B matches
        for (int j = 0; j < 2; j++) begin
          if (mt[i][j] && timer_mode_reg[`MODE_BFC0 + 2*i + j] &&
              io_ctrl_cd_reg[i][4*j + `IO_SEL]) begin
            gr_q[i][j] <= gr_q[i][j+2];
          end
        end
        // A read arms the flags that it returned as one
        if (rd_en && sel_ch && idx == `IDX_STAT) armed_q[i] <= flag_q[i];
        if (wr_en && sel_ch) begin
          unique case (idx)
            `IDX_CTRL: ctrl_q[i]         <= pwdata[7:0];
            `IDX_IOAB: io_ctrl_ab_reg[i] <= pwdata[7:0];
            `IDX_IOCD: io_ctrl_cd_reg[i] <= pwdata[7:0];
            `IDX_STAT: begin
              wclr       = armed_q[i] & ~pwdata[4:0];
              armed_q[i] <= 5'h00;
            end
            `IDX_CNT:  cnt_q[i] <= pwdata[CW-1:0];
            4'h5, 4'h6, 4'h7, 4'h8: gr_q[i][idx[1:0] - 2'h1] <= pwdata[CW-1:0];
            default: ;
          endcase
        end
        // Hardware set wins over a clear in the same cycle
        flag_q[i] <= (flag_q[i] & ~wclr) | {ovf[i], mt[i]};
      end
    end
  end

  // Waveform pins: compare actions, shared A/C and B/D control, PWM
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 2; i++) pin_q[i] <= 4'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        logic [3:0] nx;
        nx = pin_q[i];
        // A drives its own pin unless A sets a PWM period; B is driven here only when no pin is PWM
        if (!pwm_any[i]) begin
          for (int j = 0; j < 2; j++) begin
            logic bf, sl;
            bf = timer_mode_reg[`MODE_BFC0 + 2*i + j];
            sl = io_ctrl_cd_reg[i][4*j + `IO_SEL];
            if (mt[i][j]) nx[j] = act(io_ctrl_ab_reg[i][4*j +: 2], nx[j]);
            // Unbuffered C or D with select 0 steers pin A or B too
            if (mt[i][j+2] && !bf && !sl) begin
              nx[j] = act(io_ctrl_cd_reg[i][4*j +: 2], nx[j]);
            end
          end
        end
        // B keeps compare use when not PWM; unbuffered C and D with select 1 drive their own pins when not PWM
        if (pwm_any[i] && !pwm_sel_q[4*i] && mt[i][1]) begin
          nx[1] = act(io_ctrl_ab_reg[i][5:4], nx[1]);
        end
        for (int j = 2; j < 4; j++) begin
          if (!pwm_sel_q[4*i + j - 1] && mt[i][j] &&
              !timer_mode_reg[`MODE_BFC0 + 2*i + j - 2] &&
              io_ctrl_cd_reg[i][4*(j-2) + `IO_SEL]) begin
            nx[j] = act(io_ctrl_cd_reg[i][4*(j-2) +: 2], nx[j]);
          end
        end
        // PWM pins: inactive from A match, active from own match
        for (int j = 1; j < 4; j++) begin
          if (pwm_sel_q[4*i + j - 1]) begin
            if (mt[i][0]) nx[j] = ~pwm_polarity_reg[4*i + j - 1];
            if (mt[i][j]) nx[j] = pwm_polarity_reg[4*i + j - 1];
          end
        end
        pin_q[i] <= nx;
      end
    end
  end

  // Read data is captured in the setup cycle and shown in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata_q <= 32'h0000_0000;
      if (win == 2'h0) begin
        unique case (paddr)
          `OFS_START:  prdata_q[3:0] <= {count_stop_select, count_start_bit};
          `OFS_MODE:   prdata_q[7:0] <= timer_mode_reg;
          `OFS_PWMSEL: prdata_q[7:0] <= pwm_sel_q;
          `OFS_FUNC:   prdata_q[7:0] <= function_ctrl_reg;
          `OFS_DUTY:   prdata_q[7:0] <= duty_dt_reg;
          `OFS_POL:    prdata_q[7:0] <= pwm_polarity_reg;
          default: ;
        endcase
      end else if (win != 2'h3) begin
        unique case (idx)
          `IDX_CTRL: prdata_q[7:0] <= ctrl_q[win[1]];
          `IDX_IOAB: prdata_q[7:0] <= io_ctrl_ab_reg[win[1]];
          `IDX_IOCD: prdata_q[7:0] <= io_ctrl_cd_reg[win[1]];
          // Channel 0 has an unused bit that reads as one
          `IDX_STAT: prdata_q[5:0] <= {~win[1], flag_q[win[1]]};
          `IDX_CNT:  prdata_q[CW-1:0] <= cnt_q[win[1]];
          4'h5, 4'h6, 4'h7, 4'h8: prdata_q[CW-1:0] <= gr_q[win[1]][idx[1:0] - 2'h1];
          `IDX_PIN:  prdata_q[3:0] <= pin_q[win[1]];
          default: ;
        endcase
      end
    end
  end

  assign wave_pin_a = {pin_q[1][0], pin_q[0][0]};
  assign wave_pin_b = {pin_q[1][1], pin_q[0][1]};
  assign wave_pin_c = {pin_q[1][2], pin_q[0][2]};
  assign wave_pin_d = {pin_q[1][3], pin_q[0][3]};
  // Checks on channel 0; buffering is checked on channel 1, where it is used
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic stat_wr0;
  assign stat_wr0 = wr_en && win == `CH_BASE_SEL && idx == `IDX_STAT;

  match_flag_a: assert property (mt[0][0] |=> flag_q[0][0])
    else $error("A match did not set its flag");
  clear_read_a: assert property ($fell(flag_q[0][1]) |-> $past(stat_wr0) && $past(armed_q[0][1]))
    else $error("Flag cleared without read of one");
  bit5_one_a: assert property (setup && !pwrite && win == `CH_BASE_SEL && idx == `IDX_STAT
                               |=> prdata[5])
    else $error("Status bit5 did not read one");
  auto_stop_a: assert property (mt[0][0] && !count_stop_select[0] && !wr_en
                                |=> !count_start_bit[0])
    else $error("Counter kept running after A match");
  ext_gate_a: assert property (ctrl_q[0][2:0] == `SRC_EXT && !function_ctrl_reg[`FUNC_EXTEN]
                               |-> !tick[0])
    else $error("External clock counted while disabled");
  buf_load_a: assert property (mt[1][0] && timer_mode_reg[`MODE_BFC0 + 2] && io_ctrl_cd_reg[1][3]
                               && !wr_en |=> gr_q[1][0] == $past(gr_q[1][2]))
    else $error("Buffer value not moved into A");
  buf_flag_a: assert property (mt[1][2] && timer_mode_reg[`MODE_BFC0 + 2] |=> flag_q[1][2])
    else $error("Buffered C match lost its flag");
  pwm_edges_a: assert property (pwm_sel_q[0] && mt[0][1] && !mt[0][0] && !wr_en
                                |=> pin_q[0][1] == pwm_polarity_reg[0])
    else $error("PWM pin B not active after match");
  pwm_wrap_a: assert property (pwm_sel_q[0] && mt[0][0] |=> cnt_q[0] == '0)
    else $error("PWM period did not wrap at A");
  buf_cov_c:  cover property (mt[1][0] && timer_mode_reg[`MODE_BFC0 + 2] && io_ctrl_cd_reg[1][3]);
  pwm_cov_c:  cover property (pwm_sel_q[0] && mt[0][1] ##[1:50] mt[0][0]);
  clr_cov_c:  cover property (stat_wr0 && |armed_q[0] ##1 $fell(flag_q[0][0]));
  shr_cov_c:  cover property (mt[0][2] && !io_ctrl_cd_reg[0][3] && !timer_mode_reg[`MODE_BFC0]);
endmodule : timer_output_compare_pwm

// File: verilog/toc_defines.svh
// Register map, field positions and reset values of the compare timer.
// Assumes byte addressing on a 32-bit APB bus with 8 decoded address bits.
`ifndef TOC_DEFINES_SVH
`define TOC_DEFINES_SVH
// Global registers, byte offsets
`define OFS_START     8'h00
`define OFS_MODE      8'h04
`define OFS_PWMSEL    8'h08
`define OFS_FUNC      8'h0C
`define OFS_DUTY      8'h10
`define OFS_POL       8'h14
// Channel windows start at 8'h40 and 8'h80; word index inside the window
`define CH_BASE_SEL   2'h1
`define IDX_CTRL      4'h0
`define IDX_IOAB      4'h1
`define IDX_IOCD      4'h2
`define IDX_STAT      4'h3
`define IDX_CNT       4'h4
`define IDX_GRA       4'h5
`define IDX_PIN       4'h9
// Field positions
`define MODE_SYNC     0
`define MODE_BFC0     4
`define FUNC_EXTEN    7
`define CTRL_EDGE     3
`define CTRL_CLRA     5
`define CTRL_SCLR     6
`define IO_SEL        3
`define STAT_OVF      4
`define STAT_FIXED    5
// Count source code that picks the external clock pin
`define SRC_EXT       3'h5
// Reset values
`define RST_BYTE      8'h00
`define RST_GR        16'hFFFF
`endif

// File: verilog/toc_pkg.sv
// Types shared by the compare timer.
// Assumes toc_defines.svh supplies the numeric constants.
package toc_pkg;
  // Pin action on a compare match
  typedef enum logic [1:0] {
    ACT_NONE   = 2'h0,
    ACT_LOW    = 2'h1,
    ACT_HIGH   = 2'h2,
    ACT_TOGGLE = 2'h3
  } out_act_t;
endpackage : toc_pkg
